// ### core/tmpr_responder.sv
// command packet interpreter and required register set
`timescale 1ns/1ns
`default_nettype none

module tmpr_responder #(
  parameter int SETUP_CYCLES = tmpr_pkg::SETUP_APPLY_CYCLES
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // inbound packet from the link layer
  input  wire logic              cmd_valid,
  input  wire tmpr_pkg::tmpr_cmd_s cmd_packet,
  output var  logic              inbound_ready_n,
  // outbound packet to the link layer
  output var  logic              rsp_valid,
  output var  tmpr_pkg::tmpr_rsp_s rsp_packet,
  // configuration seen by the rest of the module
  output var  logic [15:0]       setup_value,
  output var  logic              setup_busy
);

  // a setup change counts as long only when it outlasts the timeout
  localparam logic LONG_SETUP = (SETUP_CYCLES > tmpr_pkg::TIMEOUT_CYCLES);
  localparam logic [31:0] SETUP_LAST = 32'(SETUP_CYCLES - 1);

  // state
  logic                inbound_ready_n_q;
  logic                rsp_valid_q;
  tmpr_pkg::tmpr_rsp_s rsp_q;
  tmpr_pkg::tmpr_rsp_s rsp_d;
  logic [3:0]          err_q;
  logic [3:0]          pend_q;
  logic [15:0]         setup_q;
  logic [15:0]         setup_shadow_q;
  logic [31:0]         setup_cnt_q;
  logic [15:0]         aea_cfg_q;
  logic [15:0]         aea_adr_q;

  // decode results
  logic        cmd_take;
  logic        fail;
  logic [3:0]  fail_code;
  logic        poll_read;
  logic        setup_start;
  logic        setup_now;
  logic        cfg_we;
  logic        adr_we;
  logic        aea_load;
  logic        win_read;
  logic        setup_done;

  function automatic logic is_aea_field(input logic [7:0] r);
    is_aea_field = (r == tmpr_pkg::REG_KIND)   ||
                   (r == tmpr_pkg::REG_MAKER)  ||
                   (r == tmpr_pkg::REG_MODEL)  ||
                   (r == tmpr_pkg::REG_SERIAL) ||
                   (r == tmpr_pkg::REG_RELEASE)||
                   (r == tmpr_pkg::REG_COMPAT);
  endfunction : is_aea_field

  function automatic logic [63:0] field_text(input logic [7:0] r);
    case (r)
      tmpr_pkg::REG_KIND:    field_text = tmpr_pkg::STR_KIND;
      tmpr_pkg::REG_MAKER:   field_text = tmpr_pkg::STR_MAKER;
      tmpr_pkg::REG_MODEL:   field_text = tmpr_pkg::STR_MODEL;
      tmpr_pkg::REG_SERIAL:  field_text = tmpr_pkg::STR_SERIAL;
      tmpr_pkg::REG_DATE:    field_text = tmpr_pkg::STR_DATE;
      tmpr_pkg::REG_RELEASE: field_text = tmpr_pkg::STR_RELEASE;
      tmpr_pkg::REG_COMPAT:  field_text = tmpr_pkg::STR_COMPAT;
      default:               field_text = 64'h0000000000000000;
    endcase
  endfunction : field_text

  function automatic logic [15:0] field_len(input logic [7:0] r);
    case (r)
      tmpr_pkg::REG_KIND:    field_len = tmpr_pkg::LEN_KIND;
      tmpr_pkg::REG_MAKER:   field_len = tmpr_pkg::LEN_MAKER;
      tmpr_pkg::REG_MODEL:   field_len = tmpr_pkg::LEN_MODEL;
      tmpr_pkg::REG_SERIAL:  field_len = tmpr_pkg::LEN_SERIAL;
      tmpr_pkg::REG_RELEASE: field_len = tmpr_pkg::LEN_RELEASE;
      tmpr_pkg::REG_COMPAT:  field_len = tmpr_pkg::LEN_COMPAT;
      default:               field_len = 16'h0000;
    endcase
  endfunction : field_len

  // bytes past the end of a field read as null
  function automatic logic [7:0] field_byte(input logic [7:0]  r,
                                            input logic [15:0] idx);
    logic [63:0] txt;
    txt = field_text(r);
    if (idx > 16'h0007) begin
      field_byte = 8'h00;
    end else begin
      field_byte = txt[8'd63 - {idx[2:0], 3'b000} -: 8];
    end
  endfunction : field_byte

  assign cmd_take = cmd_valid && !inbound_ready_n_q;

  // one command is decoded in the cycle it is taken
  always_comb begin
    rsp_d       = '0;
    fail        = 1'b0;
    fail_code   = tmpr_pkg::ERR_NONE;
    poll_read   = 1'b0;
    setup_start = 1'b0;
    setup_now   = 1'b0;
    cfg_we      = 1'b0;
    adr_we      = 1'b0;
    aea_load    = 1'b0;
    win_read    = 1'b0;
    rsp_d.reg_num = cmd_packet.reg_num;
    if (cmd_packet.rsvd != 3'b000) begin
      fail      = 1'b1;
      fail_code = tmpr_pkg::ERR_RESERVED;
    end else if (!cmd_packet.write) begin
      case (cmd_packet.reg_num)
        tmpr_pkg::REG_POLL: begin
          poll_read  = 1'b1;
          rsp_d.data = {8'h00, pend_q, err_q};
        end
        tmpr_pkg::REG_DATE: begin
          rsp_d.data = {field_byte(tmpr_pkg::REG_DATE, 16'h0000),
                        field_byte(tmpr_pkg::REG_DATE, 16'h0001)};
        end
        tmpr_pkg::REG_SETUP:   rsp_d.data = setup_q;
        tmpr_pkg::REG_AEA_CFG: rsp_d.data = aea_cfg_q;
        tmpr_pkg::REG_AEA_ADR: rsp_d.data = aea_adr_q;
        tmpr_pkg::REG_AEA_WIN: begin
          win_read   = 1'b1;
          rsp_d.data = {field_byte(aea_cfg_q[15:8], aea_adr_q),
                        field_byte(aea_cfg_q[15:8], aea_adr_q + 16'h0001)};
        end
        default: begin
          if (is_aea_field(cmd_packet.reg_num)) begin
            aea_load     = 1'b1;
            rsp_d.status = tmpr_pkg::ST_AEA;
            rsp_d.data   = field_len(cmd_packet.reg_num);
          end else begin
            fail      = 1'b1;
            fail_code = tmpr_pkg::ERR_UNKNOWN;
          end
        end
      endcase
    end else begin
      // write data in the response stays zero where it is free
      case (cmd_packet.reg_num)
        tmpr_pkg::REG_POLL: begin
        end
        tmpr_pkg::REG_SETUP: begin
          if (pend_q != 4'h0) begin
            fail      = 1'b1;
            fail_code = tmpr_pkg::ERR_BUSY;
          end else if (LONG_SETUP) begin
            setup_start  = 1'b1;
            rsp_d.status = tmpr_pkg::ST_PENDING;
            rsp_d.data   = {8'h00, tmpr_pkg::PEND_SETUP, 4'h0};
          end else begin
            setup_now = 1'b1;
          end
        end
        tmpr_pkg::REG_AEA_CFG: cfg_we = 1'b1;
        tmpr_pkg::REG_AEA_ADR: adr_we = 1'b1;
        default: begin
          // identity fields and their window are read-only, so a host
          // repeating a field write through the window is refused too
          fail      = 1'b1;
          fail_code = (cmd_packet.reg_num <= tmpr_pkg::REG_AEA_WIN) ?
                      tmpr_pkg::ERR_READONLY : tmpr_pkg::ERR_UNKNOWN;
        end
      endcase
    end
    if (fail) begin
      rsp_d.status = tmpr_pkg::ST_XE;
      rsp_d.data   = 16'h0000;
    end
  end

  // framing: ready goes high for the response cycle, low again after
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inbound_ready_n_q <= 1'b0;
      rsp_valid_q       <= 1'b0;
    end else begin
      inbound_ready_n_q <= cmd_take;
      rsp_valid_q       <= cmd_take;
    end
  end

  // response word held until the next command replaces it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_q <= '0;
    end else if (cmd_take) begin
      rsp_q <= rsp_d;
    end
  end

  // error condition: a new failure wins over the clear by a poll read
  always_ff @(posedge core_clk) begin
    if (rst) begin
      err_q <= tmpr_pkg::ERR_NONE;
    end else if (cmd_take && fail) begin
      err_q <= fail_code;
    end else if (cmd_take && poll_read) begin
      err_q <= tmpr_pkg::ERR_NONE;
    end
  end

  // long setup change runs on after its pending answer
  assign setup_done = (pend_q != 4'h0) && (setup_cnt_q == SETUP_LAST);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pend_q      <= 4'h0;
      setup_cnt_q <= 32'h00000000;
    end else if (cmd_take && setup_start) begin
      pend_q      <= tmpr_pkg::PEND_SETUP;
      setup_cnt_q <= 32'h00000000;
    end else if (setup_done) begin
      pend_q      <= 4'h0;
      setup_cnt_q <= 32'h00000000;
    end else if (pend_q != 4'h0) begin
      setup_cnt_q <= setup_cnt_q + 32'h00000001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      setup_q        <= tmpr_pkg::SETUP_RESET;
      setup_shadow_q <= tmpr_pkg::SETUP_RESET;
    end else if (cmd_take && setup_start) begin
      setup_shadow_q <= cmd_packet.data;
    end else if (cmd_take && setup_now) begin
      setup_q <= cmd_packet.data;
    end else if (setup_done) begin
      setup_q <= setup_shadow_q;
    end
  end

  // aea set: a field read points the window at that field from byte 0
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aea_cfg_q <= tmpr_pkg::AEA_CFG_RESET;
    end else if (cmd_take && aea_load) begin
      aea_cfg_q <= {cmd_packet.reg_num, 8'h00};
      aea_cfg_q[tmpr_pkg::AEA_CFG_INC_RD] <= 1'b1;
      aea_cfg_q[tmpr_pkg::AEA_CFG_INC_WR] <= 1'b1;
    end else if (cmd_take && cfg_we) begin
      aea_cfg_q <= cmd_packet.data;
    end
  end

  // the window steps two bytes per read when auto increment is on
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aea_adr_q <= tmpr_pkg::AEA_ADR_RESET;
    end else if (cmd_take && aea_load) begin
      aea_adr_q <= tmpr_pkg::AEA_ADR_RESET;
    end else if (cmd_take && adr_we) begin
      aea_adr_q <= cmd_packet.data;
    end else if (cmd_take && win_read &&
                 aea_cfg_q[tmpr_pkg::AEA_CFG_INC_RD]) begin
      aea_adr_q <= aea_adr_q + tmpr_pkg::AEA_STEP;
    end
  end

  assign inbound_ready_n = inbound_ready_n_q;
  assign rsp_valid       = rsp_valid_q;
  assign rsp_packet      = rsp_q;
  assign setup_value     = setup_q;
  assign setup_busy      = pend_q[0];

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_one_response: assert property (cmd_take |=> rsp_valid_q)
    else $error("command without response");
  a_single_pulse: assert property (rsp_valid_q |=> !rsp_valid_q)
    else $error("response pulse longer than one cycle");
  a_ready_frame: assert property (
    cmd_take |=> inbound_ready_n_q ##1 !inbound_ready_n_q)
    else $error("ready line framing wrong");
  a_echo_reg: assert property (
    cmd_take |=> rsp_q.reg_num == $past(cmd_packet.reg_num))
    else $error("register number not echoed");
  a_unknown_xe: assert property (
    cmd_take && cmd_packet.reg_num > tmpr_pkg::REG_AEA_WIN
    |=> rsp_q.status == tmpr_pkg::ST_XE && err_q == tmpr_pkg::ERR_UNKNOWN)
    else $error("unknown register not flagged");
  a_aea_length: assert property (
    cmd_take && !cmd_packet.write && cmd_packet.rsvd == 3'b000 &&
    cmd_packet.reg_num == tmpr_pkg::REG_KIND
    |=> rsp_q.status == tmpr_pkg::ST_AEA &&
        rsp_q.data == tmpr_pkg::LEN_KIND)
    else $error("aea length answer wrong");
  a_pending_form: assert property (
    rsp_valid_q && rsp_q.status == tmpr_pkg::ST_PENDING
    |-> rsp_q.data[15:8] == 8'h00 && rsp_q.data[3:0] == 4'h0 &&
        $onehot(rsp_q.data[7:4]))
    else $error("pending answer malformed");
  a_setup_pend: assert property (
    cmd_take && cmd_packet.write && cmd_packet.rsvd == 3'b000 &&
    cmd_packet.reg_num == tmpr_pkg::REG_SETUP && pend_q == 4'h0
    |=> rsp_q.status == tmpr_pkg::ST_PENDING && pend_q != 4'h0)
    else $error("long setup not answered pending");
  a_poll_shows: assert property (
    cmd_take && !cmd_packet.write && cmd_packet.rsvd == 3'b000 &&
    cmd_packet.reg_num == tmpr_pkg::REG_POLL
    |=> rsp_q.data == {8'h00, $past(pend_q), $past(err_q)})
    else $error("poll register content wrong");
  a_setup_read: assert property (
    cmd_take && !cmd_packet.write && cmd_packet.rsvd == 3'b000 &&
    cmd_packet.reg_num == tmpr_pkg::REG_SETUP
    |=> rsp_q.data == $past(setup_q))
    else $error("setup read value wrong");
  a_pend_bound: assert property (
    pend_q != 4'h0 |-> setup_cnt_q <= SETUP_LAST)
    else $error("pending operation overran");
  a_rsvd_reject: assert property (
    cmd_take && cmd_packet.rsvd != 3'b000
    |=> rsp_q.status == tmpr_pkg::ST_XE && rsp_q.data == 16'h0000 &&
        err_q == tmpr_pkg::ERR_RESERVED)
    else $error("reserved command bits not refused");
  a_readonly_write: assert property (
    cmd_take && cmd_packet.write && cmd_packet.rsvd == 3'b000 &&
    cmd_packet.reg_num >= tmpr_pkg::REG_KIND &&
    cmd_packet.reg_num <= tmpr_pkg::REG_COMPAT
    |=> rsp_q.status == tmpr_pkg::ST_XE &&
        err_q == tmpr_pkg::ERR_READONLY)
    else $error("identity write not refused");
  a_poll_clear: assert property (
    cmd_take && !cmd_packet.write && cmd_packet.rsvd == 3'b000 &&
    cmd_packet.reg_num == tmpr_pkg::REG_POLL
    |=> err_q == tmpr_pkg::ERR_NONE)
    else $error("poll read did not clear error");
  a_window_step: assert property (
    cmd_take && !cmd_packet.write && cmd_packet.rsvd == 3'b000 &&
    cmd_packet.reg_num == tmpr_pkg::REG_AEA_WIN &&
    aea_cfg_q[tmpr_pkg::AEA_CFG_INC_RD]
    |=> aea_adr_q == $past(aea_adr_q) + tmpr_pkg::AEA_STEP)
    else $error("window address did not step");
  a_setup_apply: assert property (
    setup_done |=> setup_q == $past(setup_shadow_q) && pend_q == 4'h0)
    else $error("pending setup not applied");

  c_pending: cover property (rsp_valid_q &&
                             rsp_q.status == tmpr_pkg::ST_PENDING);
  c_aea:     cover property (rsp_valid_q && rsp_q.status == tmpr_pkg::ST_AEA);
  c_xe:      cover property (rsp_valid_q && rsp_q.status == tmpr_pkg::ST_XE);
  c_done:    cover property (setup_done);
  c_window:  cover property (cmd_take && win_read);

endmodule : tmpr_responder

`default_nettype wire

// ### pkg/tmpr_pkg.sv
// constants, packet layouts and string contents for the packet responder
package tmpr_pkg;

  // clock and timing
  localparam int CLK_MHZ             = 100;
  localparam int TIMEOUT_US          = 1;
  localparam int TIMEOUT_CYCLES      = TIMEOUT_US * CLK_MHZ;
  localparam int SETUP_APPLY_US      = 50;
  localparam int SETUP_APPLY_CYCLES  = SETUP_APPLY_US * CLK_MHZ;

  // packet lengths
  localparam int CMD_BITS            = 28;
  localparam int RSP_BITS            = 26;

  // register numbers
  localparam logic [7:0] REG_POLL    = 8'h00;
  localparam logic [7:0] REG_KIND    = 8'h01;
  localparam logic [7:0] REG_MAKER   = 8'h02;
  localparam logic [7:0] REG_MODEL   = 8'h03;
  localparam logic [7:0] REG_SERIAL  = 8'h04;
  localparam logic [7:0] REG_DATE    = 8'h05;
  localparam logic [7:0] REG_RELEASE = 8'h06;
  localparam logic [7:0] REG_COMPAT  = 8'h07;
  localparam logic [7:0] REG_SETUP   = 8'h08;
  localparam logic [7:0] REG_AEA_CFG = 8'h09;
  localparam logic [7:0] REG_AEA_ADR = 8'h0a;
  localparam logic [7:0] REG_AEA_WIN = 8'h0b;

  // response status codes
  localparam logic [1:0] ST_NORMAL   = 2'h0;
  localparam logic [1:0] ST_XE       = 2'h1;
  localparam logic [1:0] ST_AEA      = 2'h2;
  localparam logic [1:0] ST_PENDING  = 2'h3;

  // error condition codes held in the poll register
  localparam logic [3:0] ERR_NONE     = 4'h0;
  localparam logic [3:0] ERR_READONLY = 4'h1;
  localparam logic [3:0] ERR_UNKNOWN  = 4'h2;
  localparam logic [3:0] ERR_BUSY     = 4'h3;
  localparam logic [3:0] ERR_RESERVED = 4'h4;

  // field positions and reset values
  localparam int AEA_CFG_INC_RD      = 0;
  localparam int AEA_CFG_INC_WR      = 1;
  localparam logic [15:0] AEA_CFG_RESET = 16'h0000;
  localparam logic [15:0] AEA_ADR_RESET = 16'h0000;
  localparam logic [15:0] SETUP_RESET   = 16'h0000;
  localparam logic [3:0]  PEND_SETUP    = 4'h1;
  localparam logic [15:0] AEA_STEP      = 16'h0002;

  // identification strings, null padded, first byte in the top lane
  localparam logic [63:0] STR_KIND    = 64'h4c41534552000000;
  localparam logic [63:0] STR_MAKER   = 64'h4d414b4552000000;
  localparam logic [63:0] STR_MODEL   = 64'h4d444c3031000000;
  localparam logic [63:0] STR_SERIAL  = 64'h534e303030310000;
  localparam logic [63:0] STR_DATE    = 64'h4430310000000000;
  localparam logic [63:0] STR_RELEASE = 64'h52312e3000000000;
  localparam logic [63:0] STR_COMPAT  = 64'h52312e3000000000;
  localparam logic [15:0] LEN_KIND    = 16'h0006;
  localparam logic [15:0] LEN_MAKER   = 16'h0006;
  localparam logic [15:0] LEN_MODEL   = 16'h0006;
  localparam logic [15:0] LEN_SERIAL  = 16'h0007;
  localparam logic [15:0] LEN_RELEASE = 16'h0005;
  localparam logic [15:0] LEN_COMPAT  = 16'h0005;

  typedef struct packed {
    logic [2:0]  rsvd;
    logic        write;
    logic [7:0]  reg_num;
    logic [15:0] data;
  } tmpr_cmd_s;

  typedef struct packed {
    logic [1:0]  status;
    logic [7:0]  reg_num;
    logic [15:0] data;
  } tmpr_rsp_s;

endpackage : tmpr_pkg

// ### testbench/tmpr_host_model.sv
// host side model that issues command packets and collects responses
`timescale 1ns/1ns
`default_nettype none

module tmpr_host_model (
  // clock
  input  wire logic                core_clk,
  // command side
  output var  logic                cmd_valid,
  output var  tmpr_pkg::tmpr_cmd_s cmd_packet,
  input  wire logic                inbound_ready_n,
  // response side
  input  wire logic                rsp_valid,
  input  wire tmpr_pkg::tmpr_rsp_s rsp_packet
);
  initial begin
    cmd_valid  = 1'b0;
    cmd_packet = '0;
  end

  // whole packet held from launch until the take edge
  task automatic send(input tmpr_pkg::tmpr_cmd_s c,
                      output tmpr_pkg::tmpr_rsp_s r, output logic ok);
    int n;
    @(posedge core_clk);
    cmd_valid  <= 1'b1;
    cmd_packet <= c;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (inbound_ready_n !== 1'b0 && n < 20);
    // released lines carry the inverse so stale data is never mistaken
    cmd_valid  <= 1'b0;
    cmd_packet <= ~c;
    #1;
    ok = (rsp_valid === 1'b1) && (inbound_ready_n === 1'b1) && (n < 20);
    r  = rsp_packet;
    @(posedge core_clk);
    #1;
    ok = ok && (rsp_valid === 1'b0);
  endtask : send
endmodule : tmpr_host_model

`default_nettype wire

// ### testbench/tmpr_responder_tb.sv
// self-checking bench for the packet responder against a reference model
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end

module tmpr_responder_tb;
  localparam int SETUP = 200;
  logic                core_clk;
  logic                rst;
  wire                 cmd_valid;
  wire tmpr_pkg::tmpr_cmd_s cmd_packet;
  wire                 inbound_ready_n;
  wire                 rsp_valid;
  wire tmpr_pkg::tmpr_rsp_s rsp_packet;
  wire [15:0]          setup_value;
  wire                 setup_busy;
  int                  fail_count = 0;
  int                  checks_done = 0;
  logic [3:0]          err;
  logic                pend;
  logic [15:0]         cfg, adr, setup, setup_n;
  logic [31:0]         seed = 32'h69f5;
  tmpr_pkg::tmpr_rsp_s exp_q[$];

  tmpr_responder #(.SETUP_CYCLES(SETUP)) dut_u (
    .core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_packet(cmd_packet), .inbound_ready_n(inbound_ready_n),
    .rsp_valid(rsp_valid), .rsp_packet(rsp_packet),
    .setup_value(setup_value), .setup_busy(setup_busy));

  tmpr_host_model host_u (
    .core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_packet(cmd_packet),
    .inbound_ready_n(inbound_ready_n), .rsp_valid(rsp_valid),
    .rsp_packet(rsp_packet));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // field length and string contents of the aea identity registers
  function automatic logic [79:0] id_of(input logic [7:0] r);
    case (r)
      8'h01: return {tmpr_pkg::LEN_KIND, tmpr_pkg::STR_KIND};
      8'h02: return {tmpr_pkg::LEN_MAKER, tmpr_pkg::STR_MAKER};
      8'h03: return {tmpr_pkg::LEN_MODEL, tmpr_pkg::STR_MODEL};
      8'h04: return {tmpr_pkg::LEN_SERIAL, tmpr_pkg::STR_SERIAL};
      8'h06: return {tmpr_pkg::LEN_RELEASE, tmpr_pkg::STR_RELEASE};
      8'h07: return {tmpr_pkg::LEN_COMPAT, tmpr_pkg::STR_COMPAT};
      default: return '0;
    endcase
  endfunction : id_of

  function automatic logic [7:0] sb(input logic [7:0] r, input int i);
    logic [79:0] t;
    t = id_of(r);
    return (i < 8) ? t[63 - 8 * i -: 8] : 8'h00;
  endfunction : sb

  task automatic model(input tmpr_pkg::tmpr_cmd_s c,
                       output tmpr_pkg::tmpr_rsp_s e);
    logic [79:0] t;
    e = '0;
    e.reg_num = c.reg_num;
    t = id_of(c.reg_num);
    if (c.rsvd != 3'h0) begin
      e.status = 2'h1;
      err = 4'h4;
    end else if (c.reg_num > 8'h0b) begin
      e.status = 2'h1;
      err = 4'h2;
    end else if (c.write) begin
      case (c.reg_num)
        8'h00: ;
        8'h08: if (pend) begin
          e.status = 2'h1;
          err = 4'h3;
        end else begin
          e.status = 2'h3;
          e.data = {8'h00, tmpr_pkg::PEND_SETUP, 4'h0};
          pend = 1'b1;
          setup_n = c.data;
        end
        8'h09: cfg = c.data;
        8'h0a: adr = c.data;
        default: begin
          e.status = 2'h1;
          err = 4'h1;
        end
      endcase
    end else begin
      case (c.reg_num)
        8'h00: begin
          e.data = {8'h00, pend ? tmpr_pkg::PEND_SETUP : 4'h0, err};
          err = 4'h0;
        end
        8'h05: e.data = tmpr_pkg::STR_DATE[63:48];
        8'h08: e.data = setup;
        8'h09: e.data = cfg;
        8'h0a: e.data = adr;
        8'h0b: begin
          e.data = {sb(cfg[15:8], adr), sb(cfg[15:8], adr + 1)};
          if (cfg[0]) adr = adr + tmpr_pkg::AEA_STEP;
        end
        default: begin
          e.status = 2'h2;
          e.data = t[79:64];
          cfg = {c.reg_num, 8'h03};
          adr = 16'h0000;
        end
      endcase
    end
  endtask : model

  task automatic xfer(input logic w, input logic [7:0] rn,
                      input logic [15:0] d, input logic [2:0] rs = 3'h0);
    tmpr_pkg::tmpr_cmd_s c;
    tmpr_pkg::tmpr_rsp_s got, exp;
    logic ok;
    c = '{rs, w, rn, d};
    model(c, exp);
    exp_q.push_back(exp);
    host_u.send(c, got, ok);
    exp = exp_q.pop_front();
    `CHK(ok, 1'b1)
    `CHK(got, exp)
  endtask : xfer

  task automatic report_and_stop;
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    err = 4'h0;
    pend = 1'b0;
    cfg = tmpr_pkg::AEA_CFG_RESET;
    adr = tmpr_pkg::AEA_ADR_RESET;
    setup = tmpr_pkg::SETUP_RESET;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK(inbound_ready_n, 1'b0)
    `CHK(setup_value, tmpr_pkg::SETUP_RESET)
    // identity registers ignore read data, most answer with a length
    for (int r = 1; r < 8; r++) xfer(1'b0, r[7:0], 16'(rnd()));
    // window walk from the last bytes of a field past its end
    xfer(1'b0, 8'h01, 16'h0000);
    xfer(1'b0, 8'h0b, 16'h0000);
    xfer(1'b1, 8'h09, 16'h0401);
    xfer(1'b1, 8'h0a, 16'h0006);
    xfer(1'b0, 8'h0b, 16'h0000);
    xfer(1'b0, 8'h0b, 16'h0000);
    xfer(1'b0, 8'h0a, 16'h0000);
    xfer(1'b0, 8'h09, 16'h0000);
    // failures, read-only, reserved and unknown codes polled and cleared
    xfer(1'b1, 8'h01, 16'(rnd()));
    xfer(1'b0, 8'h00, 16'h0000);
    xfer(1'b0, 8'h00, 16'h0000);
    xfer(1'b1, 8'h00, 16'(rnd()));
    for (int k = 1; k < 8; k++) xfer(1'b0, 8'h08, 16'h0000, k[2:0]);
    xfer(1'b0, 8'h00, 16'h0000);
    xfer(1'b0, 8'hff, 16'h0000);
    xfer(1'b1, 8'(8'h0c + rnd() % 244), 16'(rnd()));
    xfer(1'b0, 8'h00, 16'h0000);
    // long setup write answers pending, then applies later
    xfer(1'b1, 8'h08, 16'(rnd()));
    `CHK(setup_busy, 1'b1)
    xfer(1'b1, 8'h08, 16'(rnd()));
    xfer(1'b0, 8'h00, 16'h0000);
    xfer(1'b0, 8'h08, 16'h0000);
    repeat (SETUP) @(posedge core_clk);
    #1;
    pend = 1'b0;
    setup = setup_n;
    `CHK(setup_busy, 1'b0)
    `CHK(setup_value, setup_n)
    xfer(1'b0, 8'h08, 16'(rnd()));
    xfer(1'b0, 8'h00, 16'h0000);
    report_and_stop();
  end
endmodule : tmpr_responder_tb

`default_nettype wire
